/* File: hdl/hlirq_pkg.sv */
// Constants for the host-to-local interrupt unit.
// Assumes one clock domain, synchronous active-low reset.
package hlirq_pkg;
   localparam logic [31:0] NMI_ADDR      = 32'h1ffa_001c;
   localparam logic [31:0] SIR_ADDR      = 32'h1ffa_2014;
   localparam logic [31:0] RCF_ADDR      = 32'h1ffa_2018;
   localparam logic [3:0]  ATTENTION_PORT_CODE_SIR = 4'hd;
   localparam int          SIR_BITS      = 16;
   localparam int          GEN_LO        = 0;
   localparam int          EOT_LO        = 8;
   localparam int          NMI_BIT       = 0;
   localparam int          RCF_BIT       = 0;
   localparam logic [15:0] SIR_RESET     = 16'h0000;
   localparam int          NSRC          = 7;
   localparam logic [3:0]  CODE_NMI      = 4'h0;
   localparam logic [3:0]  CODE_PAR      = 4'h1;
   localparam logic [3:0]  CODE_ATTENTION_PORT     = 4'h2;
   localparam logic [3:0]  CODE_EOT      = 4'h3;
   localparam logic [3:0]  CODE_GEN      = 4'h4;
   localparam logic [3:0]  CODE_BM2      = 4'h5;
   localparam logic [3:0]  CODE_BM1      = 4'h6;
   localparam logic [3:0]  CODE_IDLE     = 4'hf;
endpackage

/* File: hdl/hlirq_src_if.sv */
// Pending-source vector passed from the latch to the encoder.
// Assumes both ends share clk.
`timescale 1ns/100ps
interface hlirq_src_if;
   logic [6:0] pend;
   logic [6:0] clr;
   modport latch (output pend, input clr);
   modport enc   (input pend, output clr);
endinterface

/* File: hdl/hlirq_latch.sv */
// Pending latches for the seven interrupt sources.
// Assumes set and clear pulses are synchronous to clk.
`timescale 1ns/100ps
module hlirq_latch (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [6:0] set,
   hlirq_src_if.latch      src
);
   typedef struct packed {
      logic [6:0] pend;
   } hlirq_latch_t;
   hlirq_latch_t q;
   hlirq_latch_t next_q;

   always_comb begin
      next_q = q;
      // Set beats clear in the same cycle
      next_q.pend = (q.pend & ~src.clr) | set;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign src.pend = q.pend;

   set_wins_a: assert property (@(posedge clk) disable iff (!resetn)
      |set |-> ##1 ((src.pend & $past(set)) == $past(set)))
      else $error("pending set lost");
endmodule // hlirq_latch

/* File: hdl/hlirq_top.sv */
// Host-to-local interrupt unit: source identification bits, host NMI,
// reset cause flag and the encoded 4-line interrupt priority encoder.
// Assumes host and local bus strobes are one-cycle pulses on clk.
`timescale 1ns/100ps
module hlirq_top (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        move_mode,
   input  wire logic        cmd_reset,
   input  wire logic        attention_port_wr,
   input  wire logic [7:0]  attention_port_wdata,
   input  wire logic        attention_port_busy,
   input  wire logic        attention_port_reject,
   input  wire logic        host_nmi_wr,
   input  wire logic [7:0]  host_nmi_wdata,
   input  wire logic        host_nmi_rd,
   input  wire logic        host_rcf_rd,
   input  wire logic        lb_wr,
   input  wire logic        lb_rd,
   input  wire logic [31:0] lb_addr,
   input  wire logic [31:0] lb_wdata,
   input  wire logic        par_req,
   input  wire logic        par_status_rd,
   input  wire logic        attention_port_req,
   input  wire logic        attention_port_port_rd,
   input  wire logic        bm1_req,
   input  wire logic        bm1_status_rd,
   input  wire logic        bm2_req,
   input  wire logic        bm2_status_rd,
   output logic [31:0]      lb_rdata,
   output logic [7:0]       host_rdata,
   output logic             attention_port_sets_busy,
   output logic [3:0]       int_code
);
   // Source index order matches code order: 0 NMI .. 6 channel 1
   localparam int S_NMI  = 0;
   localparam int S_PAR  = 1;
   localparam int S_ATTENTION_PORT = 2;
   localparam int S_EOT  = 3;
   localparam int S_GEN  = 4;
   localparam int S_BM2  = 5;
   localparam int S_BM1  = 6;
   localparam int NSRC_TOP = hlirq_pkg::NSRC - 1;

   typedef enum logic {HLIRQ_IDLE, HLIRQ_SHOW} hlirq_state_t;

   typedef struct packed {
      hlirq_state_t st;
      logic [15:0]  source_ident_bits;
      logic         nmi;
      logic         rcf;
      logic [2:0]   cur;
      logic [3:0]   code;
      logic [31:0]  lb_rdata;
      logic [7:0]   host_rdata;
      logic         sets_busy;
      logic [6:0]   clr;
   } hlirq_t;

   hlirq_t q;
   hlirq_t next_q;
   hlirq_src_if src ();
   logic [6:0] set;
   logic       sir_hit;
   logic       nmi_hit;
   logic       rcf_hit;
   logic       code_d;
   logic       sir_wr;
   logic       gen_lvl;
   logic       eot_lvl;

   assign sir_hit = (lb_addr == hlirq_pkg::SIR_ADDR);
   assign nmi_hit = (lb_addr == hlirq_pkg::NMI_ADDR);
   assign rcf_hit = (lb_addr == hlirq_pkg::RCF_ADDR);
   assign code_d  = attention_port_wr &&
                    attention_port_wdata[7:4] == hlirq_pkg::ATTENTION_PORT_CODE_SIR;
   assign sir_wr  = lb_wr && sir_hit && move_mode;
   assign gen_lvl = |q.source_ident_bits[hlirq_pkg::GEN_LO +: 8];
   assign eot_lvl = |q.source_ident_bits[hlirq_pkg::EOT_LO +: 8];

   // Group requests re-arm after each source write while bits remain
   always_comb begin
      set         = '0;
      set[S_NMI]  = host_nmi_wr && host_nmi_wdata[hlirq_pkg::NMI_BIT];
      set[S_PAR]  = par_req;
      set[S_ATTENTION_PORT] = attention_port_req;
      set[S_BM2]  = bm2_req;
      set[S_BM1]  = bm1_req;
      set[S_GEN]  = gen_lvl && !src.pend[S_GEN] &&
                    !(q.st == HLIRQ_SHOW && q.cur == 3'(S_GEN));
      set[S_EOT]  = eot_lvl && !src.pend[S_EOT] &&
                    !(q.st == HLIRQ_SHOW && q.cur == 3'(S_EOT));
   end

   hlirq_latch u_latch (
      .clk    (clk),
      .resetn (resetn),
      .set    (set),
      .src    (src)
   );

   always_comb begin
      logic [6:0] ev;
      logic [6:0] avail;
      ev     = '0;
      avail  = '0;
      next_q = q;
      next_q.clr = '0;
      next_q.sets_busy = attention_port_wr && !code_d && !attention_port_busy && !attention_port_reject;
      // Source bits: host sets by code D, local clears by zeros
      if (move_mode) begin
         if (sir_wr) begin
            next_q.source_ident_bits = q.source_ident_bits & lb_wdata[15:0];
         end
         if (code_d) begin
            next_q.source_ident_bits[attention_port_wdata[3:0]] = 1'b1;
         end
      end
      if (cmd_reset) begin
         next_q.rcf = 1'b1;
      end
      if (host_nmi_wr) begin
         next_q.nmi = host_nmi_wdata[hlirq_pkg::NMI_BIT];
      end else if (lb_rd && nmi_hit) begin
         next_q.nmi = 1'b0;
      end
      // Clearing events per source
      ev[S_NMI]  = lb_rd && nmi_hit;
      ev[S_PAR]  = par_status_rd;
      ev[S_ATTENTION_PORT] = attention_port_port_rd;
      ev[S_GEN]  = sir_wr;
      ev[S_EOT]  = sir_wr;
      ev[S_BM2]  = bm2_status_rd;
      ev[S_BM1]  = bm1_status_rd;
      next_q.clr = ev & src.pend;
      avail = src.pend & ~ev;
      // Register reads
      next_q.lb_rdata = '0;
      if (lb_rd) begin
         if (sir_hit) begin
            next_q.lb_rdata[15:0] = q.source_ident_bits;
         end else if (nmi_hit) begin
            next_q.lb_rdata[hlirq_pkg::NMI_BIT] = q.nmi;
         end else if (rcf_hit) begin
            next_q.lb_rdata[hlirq_pkg::RCF_BIT] = q.rcf;
         end
      end
      next_q.host_rdata = '0;
      if (host_nmi_rd) begin
         next_q.host_rdata[hlirq_pkg::NMI_BIT] = q.nmi;
      end else if (host_rcf_rd) begin
         next_q.host_rdata[hlirq_pkg::RCF_BIT] = q.rcf;
      end
      // Presenter
      unique case (q.st)
         HLIRQ_IDLE: begin
            next_q.code = hlirq_pkg::CODE_IDLE;
         end
         HLIRQ_SHOW: begin
            if (ev[q.cur]) begin
               next_q.st   = HLIRQ_IDLE;
               next_q.code = hlirq_pkg::CODE_IDLE;
            end
         end
      endcase
      if (avail[S_NMI] && !(q.st == HLIRQ_SHOW && q.cur == 3'(S_NMI))) begin
         next_q.st   = HLIRQ_SHOW;
         next_q.cur  = 3'(S_NMI);
         next_q.code = hlirq_pkg::CODE_NMI;
      end else if (next_q.st == HLIRQ_IDLE && |avail) begin
         next_q.st = HLIRQ_SHOW;
         for (int i = NSRC_TOP; i >= 0; i--) begin
            if (avail[i]) begin
               next_q.cur  = 3'(i);
               next_q.code = 4'(i);
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         q      <= '0;
         q.st   <= HLIRQ_IDLE;
         q.source_ident_bits  <= hlirq_pkg::SIR_RESET;
         q.code <= hlirq_pkg::CODE_IDLE;
      end else begin
         q <= next_q;
      end
   end

   // Clear acts in the cycle of its event, so a cleared source never
   // comes back from a stale pending bit
   assign src.clr        = next_q.clr;
   assign lb_rdata       = q.lb_rdata;
   assign host_rdata     = q.host_rdata;
   assign attention_port_sets_busy = q.sets_busy;
   assign int_code       = q.code;

   idle_lines_a: assert property (@(posedge clk) disable iff (!resetn)
      q.st == HLIRQ_IDLE |-> int_code == 4'hf)
      else $error("idle code not 1111");
   nmi_fast_a: assert property (@(posedge clk) disable iff (!resetn)
      host_nmi_wr && host_nmi_wdata[0] |-> ##2 int_code == 4'h0)
      else $error("nmi not shown in two cycles");
   code_range_a: assert property (@(posedge clk) disable iff (!resetn)
      int_code <= 4'h6 || int_code == 4'hf)
      else $error("unused code shown");
   hold_code_a: assert property (@(posedge clk) disable iff (!resetn)
      q.st == HLIRQ_SHOW && !ev_cur() &&
      !(src.pend[S_NMI] && q.cur != 3'(S_NMI)) |=> $stable(int_code))
      else $error("code changed before clear");
   sir_set_a: assert property (@(posedge clk) disable iff (!resetn)
      move_mode && code_d && !sir_wr |=> q.source_ident_bits[$past(attention_port_wdata[3:0])])
      else $error("code D did not set bit");
   sir_clear_a: assert property (@(posedge clk) disable iff (!resetn)
      sir_wr && !code_d |=> q.source_ident_bits == ($past(q.source_ident_bits) & $past(lb_wdata[15:0])))
      else $error("zero write clear wrong");
   rcf_set_a: assert property (@(posedge clk) disable iff (!resetn)
      cmd_reset || q.rcf |=> q.rcf)
      else $error("reset cause lost");
   busy_d_a: assert property (@(posedge clk) disable iff (!resetn)
      code_d |=> !attention_port_sets_busy)
      else $error("code D set busy");
   nmi_rdclr_a: assert property (@(posedge clk) disable iff (!resetn)
      lb_rd && nmi_hit && !host_nmi_wr |=> !q.nmi)
      else $error("nmi read did not clear");
   gen_rearm_a: assert property (@(posedge clk) disable iff (!resetn)
      gen_lvl && !sir_wr |-> ##[1:2]
      (src.pend[S_GEN] || (q.st == HLIRQ_SHOW && q.cur == 3'(S_GEN))))
      else $error("general level without request");

   nmi_cov_c:  cover property (@(posedge clk) int_code == 4'h0);
   gen_cov_c:  cover property (@(posedge clk) int_code == 4'h4);
   pre_cov_c:  cover property (@(posedge clk)
      int_code == 4'h6 ##1 int_code == 4'h0);

   function automatic logic ev_cur();
      return (q.cur == 3'(S_NMI) && lb_rd && nmi_hit) ||
             (q.cur == 3'(S_PAR) && par_status_rd) ||
             (q.cur == 3'(S_ATTENTION_PORT) && attention_port_port_rd) ||
             ((q.cur == 3'(S_GEN) || q.cur == 3'(S_EOT)) && sir_wr) ||
             (q.cur == 3'(S_BM2) && bm2_status_rd) ||
             (q.cur == 3'(S_BM1) && bm1_status_rd);
   endfunction
endmodule // hlirq_top

/* File: sim/htliu_local_svc.sv */
// Local-side service model: reads the clearing register of a presented
// parity, attention or channel code once it has stood DLY+2 cycles.
// Assumes int_code comes from the unit under test on the same clk.
`timescale 1ns/100ps
module htliu_local_svc #(
   parameter int DLY = 3
) (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       en,
   input  wire logic [3:0] int_code,
   output logic            par_status_rd = 1'b0,
   output logic            attention_port_port_rd  = 1'b0,
   output logic            bm1_status_rd = 1'b0,
   output logic            bm2_status_rd = 1'b0
);
   logic [3:0] last = 4'hf;
   int         cnt  = 0;
   // One read per presentation; a new code restarts the count
   always @(posedge clk) begin
      {par_status_rd, attention_port_port_rd, bm1_status_rd, bm2_status_rd} <= 4'h0;
      last <= int_code;
      if (!resetn || int_code != last)
         cnt <= 0;
      else if (cnt <= DLY)
         cnt <= cnt + 1;
      if (resetn && en && cnt == DLY) begin
         par_status_rd <= (int_code == hlirq_pkg::CODE_PAR);
         attention_port_port_rd  <= (int_code == hlirq_pkg::CODE_ATTENTION_PORT);
         bm1_status_rd <= (int_code == hlirq_pkg::CODE_BM1);
         bm2_status_rd <= (int_code == hlirq_pkg::CODE_BM2);
      end
   end
endmodule // htliu_local_svc

/* File: sim/test_host_to_local_interrupt_unit.sv */
// Self-checking bench for the host-to-local interrupt unit.
// Assumes the hdl package, interface, design and service model
// are compiled before it.
`timescale 1ns/100ps
module test_host_to_local_interrupt_unit;
   typedef struct {int k; logic [7:0] d; logic [3:0] c;} htliu_row_t;
   logic        clk, resetn, move_mode, cmd_reset, attention_port_wr, attention_port_busy;
   logic        attention_port_reject, host_nmi_wr, host_nmi_rd, host_rcf_rd;
   logic        lb_wr, lb_rd, par_req, attention_port_req, bm1_req, bm2_req;
   logic        par_status_rd, attention_port_port_rd, bm1_status_rd;
   logic        bm2_status_rd, attention_port_sets_busy, svc_en;
   logic [7:0]  attention_port_wdata, host_nmi_wdata, host_rdata;
   logic [31:0] lb_addr, lb_wdata, lb_rdata, rd;
   logic [3:0]  int_code;
   int          n_errors = 0;
   int          total_checks = 0;
   htliu_row_t  rows [7] = '{'{8, 0, hlirq_pkg::CODE_PAR},
      '{9, 0, hlirq_pkg::CODE_ATTENTION_PORT}, '{10, 0, hlirq_pkg::CODE_BM1},
      '{11, 0, hlirq_pkg::CODE_BM2}, '{1, 1, hlirq_pkg::CODE_NMI},
      '{0, 8'hd3, hlirq_pkg::CODE_GEN}, '{0, 8'hda, hlirq_pkg::CODE_EOT}};

   hlirq_top i_dut (.clk, .resetn, .move_mode, .cmd_reset, .attention_port_wr,
      .attention_port_wdata, .attention_port_busy, .attention_port_reject, .host_nmi_wr,
      .host_nmi_wdata, .host_nmi_rd, .host_rcf_rd, .lb_wr, .lb_rd,
      .lb_addr, .lb_wdata, .par_req, .par_status_rd, .attention_port_req,
      .attention_port_port_rd, .bm1_req, .bm1_status_rd, .bm2_req,
      .bm2_status_rd, .lb_rdata, .host_rdata, .attention_port_sets_busy,
      .int_code);
   htliu_local_svc #(.DLY(3)) i_svc (.clk, .resetn, .en(svc_en),
      .int_code, .par_status_rd, .attention_port_port_rd, .bm1_status_rd,
      .bm2_status_rd);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] g, e, input string m);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   task automatic tally_and_finish;
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wait_code(input logic [3:0] c, input int lim);
      for (int i = 0; i < lim && int_code !== c; i++)
         @(posedge clk) #1;
      chk({28'h0, int_code}, {28'h0, c}, "int_code");
      if (int_code !== c)
         tally_and_finish;
   endtask

   // One-cycle strobe: 0 attention_port, 1 nmi wr, 2 nmi rd, 3 cause rd, 4 lb wr,
   // 5 lb rd, 6 cmd reset, 7 three requests, 8..11 single requests
   task automatic strobe(input int s, input logic [31:0] a, d);
      @(posedge clk);
      lb_addr <= a;
      lb_wdata <= d;
      attention_port_wdata <= d[7:0];
      host_nmi_wdata <= d[7:0];
      case (s)
         0: attention_port_wr <= 1'b1;
         1: host_nmi_wr <= 1'b1;
         2: host_nmi_rd <= 1'b1;
         3: host_rcf_rd <= 1'b1;
         4: lb_wr <= 1'b1;
         5: lb_rd <= 1'b1;
         6: cmd_reset <= 1'b1;
         7: {par_req, bm1_req, bm2_req} <= 3'h7;
         8: par_req <= 1'b1;
         9: attention_port_req <= 1'b1;
         10: bm1_req <= 1'b1;
         default: bm2_req <= 1'b1;
      endcase
      @(posedge clk) #1;
      {attention_port_wr, host_nmi_wr, host_nmi_rd, host_rcf_rd, lb_wr, lb_rd} <= 0;
      {cmd_reset, par_req, attention_port_req, bm1_req, bm2_req} <= 0;
      rd = (s == 5) ? lb_rdata : {24'h0, host_rdata};
   endtask

   initial begin
      {resetn, move_mode, cmd_reset, attention_port_wr, attention_port_busy, svc_en} = 0;
      {attention_port_reject, host_nmi_wr, host_nmi_rd, host_rcf_rd, lb_wr} = 0;
      {lb_rd, par_req, attention_port_req, bm1_req, bm2_req} = 0;
      {attention_port_wdata, host_nmi_wdata, lb_addr, lb_wdata} = 0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      move_mode <= 1'b1;
      svc_en <= 1'b1;
      @(posedge clk) #1;
      chk({28'h0, int_code}, 32'hf, "idle after reset");
      foreach (rows[i]) begin
         strobe(rows[i].k, 32'h0, {24'h0, rows[i].d});
         wait_code(rows[i].c, 8);
         if (rows[i].k == 0) begin
            strobe(5, hlirq_pkg::SIR_ADDR, 0);
            chk(rd, 32'h1 << rows[i].d[3:0], "sir");
            strobe(4, hlirq_pkg::SIR_ADDR, ~(32'h1 << rows[i].d[3:0]));
         end
         if (rows[i].k == 1)
            strobe(5, hlirq_pkg::NMI_ADDR, 0);
         wait_code(4'hf, 10);
      end
      svc_en <= 1'b0;
      strobe(7, 0, 0);
      wait_code(hlirq_pkg::CODE_PAR, 8);
      repeat (20) @(posedge clk) #1;
      chk({28'h0, int_code}, 32'h1, "held");
      strobe(1, 0, 1);
      wait_code(hlirq_pkg::CODE_NMI, 3);
      strobe(2, 0, 0);
      chk(rd, 32'h1, "nmi host");
      strobe(5, hlirq_pkg::NMI_ADDR, 0);
      chk(rd, 32'h1, "nmi local");
      strobe(2, 0, 0);
      chk(rd, 32'h0, "nmi cleared");
      wait_code(hlirq_pkg::CODE_PAR, 8);
      svc_en <= 1'b1;
      wait_code(hlirq_pkg::CODE_BM2, 10);
      wait_code(hlirq_pkg::CODE_BM1, 10);
      wait_code(4'hf, 10);
      strobe(0, 0, 8'hd1);
      strobe(0, 0, 8'hd2);
      wait_code(hlirq_pkg::CODE_GEN, 8);
      strobe(4, hlirq_pkg::SIR_ADDR, 32'hffff_ffff);
      strobe(5, hlirq_pkg::SIR_ADDR, 0);
      chk(rd, 32'h0000_0006, "ones kept");
      strobe(4, hlirq_pkg::SIR_ADDR, 32'hffff_fffd);
      wait_code(4'hf, 3);
      wait_code(hlirq_pkg::CODE_GEN, 8);
      strobe(5, hlirq_pkg::SIR_ADDR, 0);
      chk(rd, 32'h0000_0004, "one cleared");
      strobe(4, hlirq_pkg::SIR_ADDR, 0);
      wait_code(4'hf, 8);
      strobe(0, 0, 8'h51);
      chk({31'h0, attention_port_sets_busy}, 32'h1, "busy set");
      move_mode <= 1'b0;
      strobe(0, 0, 8'hd5);
      strobe(5, hlirq_pkg::SIR_ADDR, 0);
      chk(rd, 32'h0, "no move mode");
      move_mode <= 1'b1;
      attention_port_busy <= 1'b1;
      attention_port_reject <= 1'b1;
      strobe(0, 0, 8'hd9);
      chk({31'h0, attention_port_sets_busy}, 32'h0, "code d no busy");
      wait_code(hlirq_pkg::CODE_EOT, 8);
      strobe(4, hlirq_pkg::SIR_ADDR, 0);
      strobe(5, 32'h1ffa_0000, 0);
      chk(rd, 32'h0, "unmapped");
      strobe(6, 0, 0);
      strobe(3, 0, 0);
      chk(rd, 32'h1, "cause host");
      strobe(5, hlirq_pkg::RCF_ADDR, 0);
      chk(rd, 32'h1, "cause local");
      resetn = 1'b0;
      repeat (2) @(posedge clk) #1;
      resetn = 1'b1;
      strobe(3, 0, 0);
      chk(rd, 32'h0, "cause cleared");
      chk({28'h0, int_code}, 32'hf, "idle again");
      tally_and_finish;
   end
endmodule // test_host_to_local_interrupt_unit
